// *** ubb_pkg.sv ***
package ubb_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int N_RATES = 29;
	localparam int unsigned BAUD_RATE [N_RATES] = '{
		300, 600, 1200, 1800, 2400, 4000, 4800, 7200, 9600, 14400,
		16000, 19200, 28800, 38400, 51200, 56000, 57600, 64000,
		76800, 115200, 128000, 153600, 230400, 250000, 256000,
		460800, 500000, 576000, 921600};
	localparam logic [4:0] IDX_MAX_RATE = 5'h1C;
	localparam logic [4:0] BAUD_RST = 5'h08;
	localparam int DIV_W = 18;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_BAUD = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_LOCK = 8'h0C;
	localparam logic [7:0] OFF_IDS = 8'h10;
	localparam logic [7:0] OFF_POWER = 8'h14;
	localparam logic [7:0] OFF_SERIAL = 8'h18;
	localparam logic [7:0] OFF_DESCR = 8'h1C;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	localparam logic [1:0] DB_5 = 2'h0;
	localparam logic [1:0] DB_7 = 2'h2;
	localparam logic [1:0] STOP_1 = 2'h0;
	localparam logic [1:0] STOP_1P5 = 2'h1;
	localparam logic [1:0] STOP_2 = 2'h2;
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_EVEN = 3'h1;
	localparam logic [2:0] PAR_ODD = 3'h2;
	localparam logic [2:0] PAR_MARK = 3'h3;
	localparam logic [2:0] PAR_SPACE = 3'h4;
	localparam logic [1:0] FLOW_NONE = 2'h0;
	localparam logic [1:0] FLOW_RTS = 2'h1;
	localparam logic [1:0] FLOW_DTR = 2'h2;
	localparam logic [1:0] FLOW_XON = 2'h3;

	typedef struct packed {
		logic dtr_on;
		logic rts_on;
		logic [1:0] flow;
		logic [2:0] parity;
		logic [1:0] stop;
		logic [1:0] dbits;
	} ubb_cfg_t;
	localparam int CFG_W = 11;
	localparam ubb_cfg_t CFG_RST = 11'h003;

	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;

	localparam int ST_SUSP = 0;
	localparam int ST_CONF = 1;
	localparam int ST_CTS = 2;
	localparam int ST_DSR = 3;
	localparam int ST_DCD = 4;
	localparam int ST_RI = 5;
	localparam int ST_TXBUSY = 6;
	localparam int ST_XOFF = 7;
	localparam int ST_OVR = 8;
	localparam int ST_PERR = 9;
	localparam int ST_FERR = 10;
	localparam int LOCK_BIT = 0;
	localparam int PROG_BIT = 1;

	// identity defaults: arbitrary values
	localparam logic [15:0] VID_DFLT = 16'h1234;
	localparam logic [15:0] PID_DFLT = 16'h5678;
	localparam logic [15:0] REL_DFLT = 16'h0A01;
	localparam logic [7:0] PWR_ATTR_DFLT = 8'h80;
	localparam logic [7:0] MAX_PWR_DFLT = 8'h32;
	localparam logic [31:0] SERIAL_DFLT = 32'h30303031;
	localparam logic [31:0] DESCR_DFLT = 32'h55415254;

	function automatic logic [DIV_W-1:0] baud_div(input logic [4:0] i);
		baud_div = DIV_W'(CLK_HZ / BAUD_RATE[i]);
	endfunction
endpackage

// *** ubb_top.sv ***
`timescale 1ns/1ps
// Function
// - bytes move between the usb streams and the serial line, except xon/xoff consumed under software flow and overrun bytes; host commands steer the port.
// - suspend signalling puts the block in suspend and asserts both indicators.
// - after device reset both indicators stay asserted until configuration completes, a resume or a bus reset.
// - resume or bus reset leave suspend and deassert both indicators; device reset enters suspend.
// - during device reset both indicator pins are released and float high.
// - in suspend one indicator is driven high and the other low.
// - flow control is selectable as rts/cts, dtr/dsr or xon/xoff.
// - every modem and handshake line is active low.
// - frames carry 5 to 8 data bits and 1, 1.5 or 2 stops, 1.5 only with 5 bits.
// - parity is none, even, odd, mark or space.
// - the baud table runs from 300 to 921600 including the odd rates.
// - 921600 is accepted only with 7 or 8 data bits.
// - an unprogrammed store reports default descriptors, attributes 80h, power 32h.
// - the host writes vendor, product, power, release, serial and description.
// - once locked the descriptor store refuses every write until device reset restores the defaults.
module ubb_top (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic usb_suspend_det,
	input wire logic usb_resume,
	input wire logic usb_bus_reset,
	input wire logic usb_configured,
	input wire logic [7:0] usb_out_data,
	input wire logic usb_out_valid,
	output logic usb_out_ready,
	output logic [7:0] usb_in_data,
	output logic usb_in_valid,
	input wire logic usb_in_ready,
	output logic txd,
	input wire logic rxd,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic dcd_n,
	input wire logic ri_n,
	output logic rts_n,
	output logic dtr_n,
	output logic suspend_hi,
	output logic suspend_hi_oe,
	output logic suspend_lo,
	output logic suspend_lo_oe
);
	import ubb_pkg::*;

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
		TX_PAR = 5'h08, TX_STOP = 5'h10
	} ubb_tx_t;
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
		RX_PAR = 5'h08, RX_STOP = 5'h10
	} ubb_rx_t;

	function automatic logic par_calc(input logic [7:0] d,
		input logic [1:0] db, input logic [2:0] mode);
		logic [7:0] mask;
		logic x;
		mask = 8'hFF >> (3'h3 - {1'b0, db});
		x = ^(d & mask);
		case (mode)
			PAR_EVEN: par_calc = x;
			PAR_ODD: par_calc = ~x;
			PAR_MARK: par_calc = 1'b1;
			default: par_calc = 1'b0;
		endcase
	endfunction

	// pin synchronisers, first stage read only by the second
	logic [4:0] pin_s1, pin_s2;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pin_s1 <= 5'h1F;
			pin_s2 <= 5'h1F;
		end else begin
			pin_s1 <= {rxd, cts_n, dsr_n, dcd_n, ri_n};
			pin_s2 <= pin_s1;
		end
	end
	wire rxd_s = pin_s2[4];
	wire cts_on = !pin_s2[3];
	wire dsr_on = !pin_s2[2];
	wire dcd_on = !pin_s2[1];
	wire ri_on = !pin_s2[0];

	// bus slave: zero wait, registered read data
	wire ahb_sel = hsel && htrans[1] && hready;
	logic wr_pend;
	logic [7:0] wr_addr;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= ahb_sel && hwrite && (hsize == SIZE_WORD);
			wr_addr <= haddr[7:0];
		end
	end
	wire wr_ctrl = wr_pend && (wr_addr == OFF_CTRL);
	wire wr_baud = wr_pend && (wr_addr == OFF_BAUD);
	wire wr_stat = wr_pend && (wr_addr == OFF_STATUS);
	wire wr_lock = wr_pend && (wr_addr == OFF_LOCK);
	wire wr_desc = wr_pend && (wr_addr[7:4] == OFF_IDS[7:4]);

	ubb_cfg_t cfg;
	logic [4:0] baud_idx;
	wire ubb_cfg_t wcfg = ubb_cfg_t'(hwdata[CFG_W-1:0]);
	wire cfg_ok = (wcfg.parity <= PAR_SPACE) &&
		(wcfg.stop <= STOP_2) && (wcfg.stop != STOP_1P5 ||
		wcfg.dbits == DB_5) &&
		!(baud_idx == IDX_MAX_RATE && wcfg.dbits < DB_7);
	wire baud_ok = (hwdata[4:0] <= IDX_MAX_RATE) &&
		!(hwdata[4:0] == IDX_MAX_RATE && cfg.dbits < DB_7);
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cfg <= CFG_RST;
			baud_idx <= BAUD_RST;
		end else begin
			if (wr_ctrl && cfg_ok)
				cfg <= wcfg;
			if (wr_baud && baud_ok)
				baud_idx <= hwdata[4:0];
		end
	end
	wire [DIV_W-1:0] div = baud_div(baud_idx);
	wire [3:0] nbits = {2'h0, cfg.dbits} + 4'h5;
	wire [DIV_W+1:0] stop_len = (DIV_W+2)'(({2'h0, div} *
		(DIV_W+2)'({1'b0, cfg.stop} + 3'h2)) >> 1);

	// descriptor store, reset to defaults so an empty store reports them
	logic locked, programmed;
	logic [31:0] ids, power, serial, descr;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			locked <= 1'b0;
			programmed <= 1'b0;
			ids <= {PID_DFLT, VID_DFLT};
			power <= {REL_DFLT, MAX_PWR_DFLT, PWR_ATTR_DFLT};
			serial <= SERIAL_DFLT;
			descr <= DESCR_DFLT;
		end else begin
			if (wr_lock && hwdata[LOCK_BIT])
				locked <= 1'b1;
			if (wr_desc && !locked) begin
				programmed <= 1'b1;
				if (wr_addr == OFF_IDS)
					ids <= hwdata;
				else if (wr_addr == OFF_POWER)
					power <= hwdata;
				else if (wr_addr == OFF_SERIAL)
					serial <= hwdata;
				else if (wr_addr == OFF_DESCR)
					descr <= hwdata;
			end
		end
	end

	// suspend tracking
	logic suspended, configured;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			suspended <= 1'b1;
			configured <= 1'b0;
			suspend_hi <= 1'b1;
			suspend_lo <= 1'b1;
			suspend_hi_oe <= 1'b0;
			suspend_lo_oe <= 1'b0;
		end else begin
			suspend_hi_oe <= 1'b1;
			suspend_lo_oe <= 1'b1;
			suspend_hi <= suspended;
			suspend_lo <= !suspended;
			if (usb_bus_reset) begin
				suspended <= 1'b0;
				configured <= 1'b0;
			end else if (usb_resume) begin
				suspended <= 1'b0;
			end else if (usb_suspend_det) begin
				suspended <= 1'b1;
			end else if (usb_configured) begin
				suspended <= 1'b0;
				configured <= 1'b1;
			end
		end
	end

	// transmitter
	ubb_tx_t tx_state;
	logic [DIV_W+1:0] tx_cnt;
	logic [7:0] tx_byte;
	logic [2:0] tx_bit;
	logic xoff;
	wire tx_allow = (cfg.flow == FLOW_RTS) ? cts_on :
		(cfg.flow == FLOW_DTR) ? dsr_on :
		(cfg.flow == FLOW_XON) ? !xoff : 1'b1;
	wire tx_take = usb_out_ready && usb_out_valid;
	wire tx_tick = (tx_cnt == (DIV_W+2)'(1));
	wire tx_last = ({1'b0, tx_bit} == nbits - 4'h1);
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tx_state <= TX_IDLE;
			tx_cnt <= '0;
			tx_byte <= 8'h00;
			tx_bit <= 3'h0;
			txd <= 1'b1;
			usb_out_ready <= 1'b0;
		end else begin
			usb_out_ready <= 1'b0;
			if (!tx_tick)
				tx_cnt <= tx_cnt - (DIV_W+2)'(1);
			case (tx_state)
				TX_IDLE: begin
					txd <= 1'b1;
					usb_out_ready <= tx_allow && !tx_take;
					if (tx_take) begin
						tx_byte <= usb_out_data;
						tx_cnt <= {2'h0, div};
						txd <= 1'b0;
						tx_state <= TX_START;
					end
				end
				TX_START: if (tx_tick) begin
					txd <= tx_byte[0];
					tx_bit <= 3'h0;
					tx_cnt <= {2'h0, div};
					tx_state <= TX_DATA;
				end
				TX_DATA: if (tx_tick) begin
					tx_cnt <= {2'h0, div};
					if (!tx_last) begin
						tx_bit <= tx_bit + 3'h1;
						txd <= tx_byte[tx_bit + 3'h1];
					end else if (cfg.parity != PAR_NONE) begin
						txd <= par_calc(tx_byte, cfg.dbits, cfg.parity);
						tx_state <= TX_PAR;
					end else begin
						txd <= 1'b1;
						tx_cnt <= stop_len;
						tx_state <= TX_STOP;
					end
				end
				TX_PAR: if (tx_tick) begin
					txd <= 1'b1;
					tx_cnt <= stop_len;
					tx_state <= TX_STOP;
				end
				TX_STOP: if (tx_tick)
					tx_state <= TX_IDLE;
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// receiver, samples mid-bit; a byte waiting in usb_in_data makes the next data byte an overrun
	ubb_rx_t rx_state;
	logic [DIV_W-1:0] rx_cnt;
	logic [7:0] rx_shift;
	logic [2:0] rx_bit;
	logic rx_par;
	logic ev_ovr, ev_perr, ev_ferr;
	wire rx_tick = (rx_cnt == DIV_W'(1));
	wire rx_last = ({1'b0, rx_bit} == nbits - 4'h1);
	wire sw_flow = (cfg.flow == FLOW_XON);
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			rx_shift <= 8'h00;
			rx_bit <= 3'h0;
			rx_par <= 1'b0;
			usb_in_data <= 8'h00;
			usb_in_valid <= 1'b0;
			xoff <= 1'b0;
			ev_ovr <= 1'b0;
			ev_perr <= 1'b0;
			ev_ferr <= 1'b0;
		end else begin
			ev_ovr <= 1'b0;
			ev_perr <= 1'b0;
			ev_ferr <= 1'b0;
			if (usb_in_valid && usb_in_ready)
				usb_in_valid <= 1'b0;
			if (!sw_flow)
				xoff <= 1'b0;
			if (!rx_tick)
				rx_cnt <= rx_cnt - DIV_W'(1);
			case (rx_state)
				RX_IDLE: if (!rxd_s) begin
					rx_cnt <= div >> 1;
					rx_shift <= 8'h00;
					rx_state <= RX_START;
				end
				RX_START: if (rx_tick) begin
					rx_cnt <= div;
					rx_bit <= 3'h0;
					rx_state <= rxd_s ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rx_tick) begin
					rx_cnt <= div;
					rx_shift[rx_bit] <= rxd_s;
					rx_bit <= rx_bit + 3'h1;
					if (rx_last)
						rx_state <= (cfg.parity != PAR_NONE) ?
							RX_PAR : RX_STOP;
				end
				RX_PAR: if (rx_tick) begin
					rx_cnt <= div;
					rx_par <= rxd_s;
					rx_state <= RX_STOP;
				end
				RX_STOP: if (rx_tick) begin
					rx_state <= RX_IDLE;
					ev_ferr <= !rxd_s;
					ev_perr <= (cfg.parity != PAR_NONE) && (rx_par !=
						par_calc(rx_shift, cfg.dbits, cfg.parity));
					if (sw_flow && rx_shift == XOFF_CHAR)
						xoff <= 1'b1;
					else if (sw_flow && rx_shift == XON_CHAR)
						xoff <= 1'b0;
					else if (usb_in_valid && !usb_in_ready)
						ev_ovr <= 1'b1;
					else begin
						usb_in_data <= rx_shift;
						usb_in_valid <= 1'b1;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// sticky errors: write one clears, a same-cycle event wins
	logic [2:0] err;
	wire [2:0] err_clr = wr_stat ? hwdata[ST_FERR:ST_OVR] : 3'h0;
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			err <= 3'h0;
		else
			err <= (err & ~err_clr) | {ev_ferr, ev_perr, ev_ovr};
	end

	// modem outputs; under hardware flow the line drops while a byte waits
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else begin
			rts_n <= (cfg.flow == FLOW_RTS) ? usb_in_valid :
				!cfg.rts_on;
			dtr_n <= (cfg.flow == FLOW_DTR) ? usb_in_valid :
				!cfg.dtr_on;
		end
	end

	wire [31:0] status = {21'h0, err, xoff, tx_state != TX_IDLE,
		ri_on, dcd_on, dsr_on, cts_on, configured, suspended};
	logic [31:0] rd_mux;
	always_comb begin
		if (haddr[7:0] == OFF_CTRL)
			rd_mux = {21'h0, cfg};
		else if (haddr[7:0] == OFF_BAUD)
			rd_mux = {27'h0, baud_idx};
		else if (haddr[7:0] == OFF_STATUS)
			rd_mux = status;
		else if (haddr[7:0] == OFF_LOCK)
			rd_mux = {30'h0, programmed, locked};
		else if (haddr[7:0] == OFF_IDS)
			rd_mux = ids;
		else if (haddr[7:0] == OFF_POWER)
			rd_mux = power;
		else if (haddr[7:0] == OFF_SERIAL)
			rd_mux = serial;
		else if (haddr[7:0] == OFF_DESCR)
			rd_mux = descr;
		else
			rd_mux = 32'h0;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (ahb_sel && !hwrite)
				hrdata <= rd_mux;
		end
	end
endmodule // ubb_top

// *** ubb_properties.sv ***
`timescale 1ns/1ps
module ubb_chk (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic usb_suspend_det,
	input wire logic usb_resume,
	input wire logic usb_bus_reset,
	input wire logic usb_out_valid,
	input wire logic usb_out_ready,
	input wire logic txd,
	input wire logic suspend_hi,
	input wire logic suspend_hi_oe,
	input wire logic suspend_lo,
	input wire logic suspend_lo_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_on;
		suspend_hi && !suspend_lo;
	endsequence
	sequence s_off;
		!suspend_hi && suspend_lo;
	endsequence
	// first sampled edge out of reset still shows the reset values
	property p_float;
		$rose(rst_b) |-> !suspend_hi_oe && !suspend_lo_oe;
	endproperty
	property p_boot;
		$rose(rst_b) |=> suspend_hi_oe && suspend_lo_oe ##0 s_on;
	endproperty
	property p_comp;
		suspend_hi_oe |-> suspend_hi != suspend_lo;
	endproperty
	// indicators trail the state register by one cycle
	property p_enter;
		usb_suspend_det && !usb_resume && !usb_bus_reset |-> ##2 s_on;
	endproperty
	property p_exit;
		usb_resume || usb_bus_reset |-> ##2 s_off;
	endproperty
	property p_start;
		$fell(txd) |-> (!txd) [*8];
	endproperty
	property p_take;
		usb_out_valid && usb_out_ready |=> !usb_out_ready ##[0:30] !txd;
	endproperty
	property p_idle;
		usb_out_ready |-> txd;
	endproperty
	a_float: assert property (p_float) else $error("pins driven in reset");
	a_boot: assert property (p_boot) else $error("no boot suspend");
	a_comp: assert property (p_comp) else $error("same polarity");
	a_enter: assert property (p_enter) else $error("no suspend");
	a_exit: assert property (p_exit) else $error("no wake");
	a_start: assert property (p_start) else $error("short start");
	a_take: assert property (p_take) else $error("byte not sent");
	a_idle: assert property (p_idle) else $error("idle not high");
endmodule // ubb_chk
bind ubb_top ubb_chk i_chk (
	.ref_clk(ref_clk), .rst_b(rst_b), .usb_suspend_det(usb_suspend_det),
	.usb_resume(usb_resume), .usb_bus_reset(usb_bus_reset),
	.usb_out_valid(usb_out_valid), .usb_out_ready(usb_out_ready),
	.txd(txd), .suspend_hi(suspend_hi), .suspend_hi_oe(suspend_hi_oe),
	.suspend_lo(suspend_lo), .suspend_lo_oe(suspend_lo_oe)
);

// *** ubb_peer.sv ***
`timescale 1ns/1ps
module ubb_peer #(
	parameter int BIT = 27
) (
	input wire logic ref_clk,
	input wire logic txd,
	input wire logic [3:0] nrx,
	output logic rxd,
	output logic [9:0] rx_word,
	output logic rx_stb
);
	logic [9:0] w;
	int i;
	initial begin
		rxd = 1'b1;
		rx_stb = 1'b0;
		rx_word = 10'h0;
	end
	// samples mid-bit; nrx counts data plus parity
	always begin
		@(negedge txd);
		w = 10'h0;
		repeat (BIT / 2) @(posedge ref_clk);
		for (i = 0; i <= nrx; i++) begin
			repeat (BIT) @(posedge ref_clk);
			w[i] = txd;
		end
		rx_word <= w;
		rx_stb <= 1'b1;
		@(posedge ref_clk);
		rx_stb <= 1'b0;
	end
	task automatic send(input logic [9:0] b, input int n);
		int k;
		rxd <= 1'b0;
		repeat (BIT) @(posedge ref_clk);
		for (k = 0; k < n; k++) begin
			rxd <= b[k];
			repeat (BIT) @(posedge ref_clk);
		end
		rxd <= 1'b1;
		repeat (BIT) @(posedge ref_clk);
	endtask
endmodule // ubb_peer

// *** ubb_tb.sv ***
`timescale 1ns/1ps
module testbench;
	import ubb_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [2:0] ev = 3'h0;
	logic usb_cfg = 1'b0;
	logic [7:0] out_data = 8'h0;
	logic out_valid = 1'b0;
	logic in_ready = 1'b1;
	logic [3:0] modem_n = 4'hF;
	logic [3:0] nrx = 4'h9;
	logic [31:0] hrdata;
	logic hready, hresp, out_ready, in_valid, txd, rxd, rx_stb;
	logic [7:0] in_data;
	logic [9:0] rx_word;
	logic sus_hi, sus_hi_oe, sus_lo, sus_lo_oe, rts_n, dtr_n;
	wire [3:0] sus = {sus_hi_oe, sus_lo_oe, sus_hi, sus_lo};
	logic [31:0] exp_q[$];
	logic [31:0] rd_val;
	logic [7:0] lfsr = 8'h04;
	int err_count = 0;
	int compares = 0;
	int p;
	event rd_ev;
	always #20 ref_clk = ~ref_clk;
	ubb_top i_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.usb_suspend_det(ev[2]), .usb_resume(ev[1]), .usb_bus_reset(ev[0]),
		.usb_configured(usb_cfg), .usb_out_data(out_data),
		.usb_out_valid(out_valid), .usb_out_ready(out_ready),
		.usb_in_data(in_data), .usb_in_valid(in_valid),
		.usb_in_ready(in_ready), .txd(txd), .rxd(rxd), .cts_n(modem_n[3]),
		.dsr_n(modem_n[2]), .dcd_n(modem_n[1]), .ri_n(modem_n[0]),
		.rts_n(rts_n), .dtr_n(dtr_n), .suspend_hi(sus_hi),
		.suspend_hi_oe(sus_hi_oe), .suspend_lo(sus_lo),
		.suspend_lo_oe(sus_lo_oe)
	);
	ubb_peer i_peer (
		.ref_clk(ref_clk), .txd(txd), .nrx(nrx), .rxd(rxd),
		.rx_word(rx_word), .rx_stb(rx_stb)
	);
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [9:0] frame(input logic [7:0] b,
			input logic [2:0] m);
		logic pb;
		pb = (m == PAR_EVEN) ? ^b : (m == PAR_ODD) ? ~^b : (m == PAR_MARK);
		frame = (m == PAR_NONE) ? {2'h1, b} : {1'b1, pb, b};
	endfunction
	task automatic wrap_up;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic give_up;
		err_count++;
		wrap_up();
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic take(input logic [31:0] v);
		check(v, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEADBEEF);
	endtask
	always @(rd_ev) take(rd_val);
	always @(posedge ref_clk) begin
		if (rx_stb === 1'b1)
			take({22'h0, rx_word});
		if (in_valid === 1'b1 && in_ready)
			take({24'h0, in_data});
	end
	task automatic hwait;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50)
			give_up();
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= SIZE_WORD;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		rd_val = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		ahb(1'b0, a, 32'h0);
		->rd_ev;
	endtask
	// frames take about 300 cycles, so 2000 leaves room for six
	task automatic drain;
		int n;
		for (n = 0; n < 2000 && exp_q.size() > 0; n++)
			@(posedge ref_clk);
		if (n >= 2000)
			give_up();
	endtask
	task automatic tx(input logic [7:0] b, input logic [9:0] e);
		int n;
		exp_q.push_back({22'h0, e});
		out_data <= b;
		out_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (out_ready !== 1'b1 && n < 400);
		out_valid <= 1'b0;
		if (n >= 400)
			give_up();
		drain();
	endtask
	// indicators trail the event by two edges, so four is settled
	task automatic pulse(input logic [2:0] m, input logic [3:0] e);
		ev <= m;
		@(posedge ref_clk);
		ev <= 3'h0;
		repeat (4) @(posedge ref_clk);
		check({28'h0, sus}, {28'h0, e});
	endtask
	initial begin
		repeat (7) @(posedge ref_clk);
		check({26'h0, sus, rts_n, dtr_n}, 32'hF);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		rd(OFF_CTRL, 32'h3);
		rd(OFF_POWER, {REL_DFLT, MAX_PWR_DFLT, PWR_ATTR_DFLT});
		rd(8'h40, 32'h0);
		rd(OFF_STATUS, 32'h1);
		check({28'h0, sus}, 32'hE);
		usb_cfg <= 1'b1;
		modem_n <= 4'hD;
		@(posedge ref_clk);
		usb_cfg <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(OFF_STATUS, 32'h12);
		ahb(1'b1, OFF_BAUD, 32'h1D);
		rd(OFF_BAUD, 32'h8);
		ahb(1'b1, OFF_BAUD, {27'h0, IDX_MAX_RATE});
		ahb(1'b1, OFF_CTRL, 32'h10);
		rd(OFF_CTRL, 32'h3);
		ahb(1'b1, OFF_CTRL, 32'h53);
		rd(OFF_CTRL, 32'h3);
		ahb(1'b1, OFF_CTRL, 32'h7);
		rd(OFF_CTRL, 32'h3);
		for (p = 0; p < 5; p++) begin
			ahb(1'b1, OFF_CTRL, {25'h0, p[2:0], 4'h3});
			nrx <= (p == 0) ? 4'h8 : 4'h9;
			lfsr = lfsr_next(lfsr);
			tx(lfsr, frame(lfsr, p[2:0]));
			lfsr = lfsr_next(lfsr);
			exp_q.push_back({24'h0, lfsr});
			i_peer.send(frame(lfsr, p[2:0]), (p == 0) ? 8 : 9);
			drain();
		end
		// space parity is set: a one in the parity slot is an error
		exp_q.push_back(32'h55);
		i_peer.send(10'h155, 9);
		drain();
		rd(OFF_STATUS, 32'h212);
		ahb(1'b1, OFF_STATUS, 32'h200);
		rd(OFF_STATUS, 32'h12);
		ahb(1'b1, OFF_CTRL, 32'h83);
		nrx <= 4'h8;
		repeat (2) @(posedge ref_clk);
		out_valid <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check({31'h0, out_ready}, 32'h0);
		modem_n <= 4'h5;
		tx(8'hC3, frame(8'hC3, PAR_NONE));
		ahb(1'b1, OFF_CTRL, 32'h183);
		i_peer.send(frame(XOFF_CHAR, PAR_NONE), 8);
		rd(OFF_STATUS, 32'h96);
		out_data <= 8'h3C;
		out_valid <= 1'b1;
		repeat (10) @(posedge ref_clk);
		check({31'h0, out_ready}, 32'h0);
		// valid drops so nothing is taken while xon arrives
		out_valid <= 1'b0;
		i_peer.send(frame(XON_CHAR, PAR_NONE), 8);
		tx(8'h3C, frame(8'h3C, PAR_NONE));
		ahb(1'b1, OFF_CTRL, 32'h603);
		repeat (2) @(posedge ref_clk);
		check({30'h0, rts_n, dtr_n}, 32'h0);
		ahb(1'b1, OFF_IDS, 32'hA5A55A5A);
		rd(OFF_IDS, 32'hA5A55A5A);
		ahb(1'b1, OFF_LOCK, 32'h1);
		ahb(1'b1, OFF_IDS, 32'h0);
		rd(OFF_IDS, 32'hA5A55A5A);
		rd(OFF_LOCK, 32'h3);
		rst_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check({28'h0, sus}, 32'h3);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check({28'h0, sus}, 32'hE);
		rd(OFF_IDS, {PID_DFLT, VID_DFLT});
		ahb(1'b1, OFF_CTRL, 32'h4);
		rd(OFF_CTRL, 32'h4);
		ahb(1'b1, OFF_BAUD, {27'h0, IDX_MAX_RATE});
		rd(OFF_BAUD, 32'h8);
		pulse(3'h4, 4'hE);
		pulse(3'h2, 4'hD);
		pulse(3'h4, 4'hE);
		pulse(3'h1, 4'hD);
		rd(OFF_STATUS, 32'h14);
		wrap_up();
	end
endmodule // testbench
